// File: dior_pkg.sv
// Purpose: shared constants and types for digital input conditioning
// Assumes: one 20 MHz clock, objects reached by index over a word port
// Notes: object indices are local choices of this block
package dior_pkg;
    // ------------------------------------------------------------
    // sizes and timing
    // ------------------------------------------------------------
    localparam int NUM_IN = 16;
    localparam int WORD_W = 32;
    localparam int NUM_ROUTE = 32;
    localparam int CLK_HZ = 20_000_000;
    localparam int SAMPLE_PERIOD_MS = 1;
    localparam int SAMPLE_CYCLES = CLK_HZ / 1000 * SAMPLE_PERIOD_MS;
    localparam int LEVEL_LSB = 16;
    localparam int SF_NEG_LIMIT = 0;
    localparam int SF_POS_LIMIT = 1;
    localparam int SF_HOME = 2;
    localparam int SF_INTERLOCK = 3;
    localparam int OUT_BRAKE = 0;

    // ------------------------------------------------------------
    // object indices
    // ------------------------------------------------------------
    localparam logic [7:0] IDX_INPUT_WORD = 8'h00;
    localparam logic [7:0] IDX_OUTPUT_WORD = 8'h01;
    localparam logic [7:0] IDX_SF_ENABLE = 8'h10;
    localparam logic [7:0] IDX_POLARITY = 8'h11;
    localparam logic [7:0] IDX_FORCE_EN = 8'h12;
    localparam logic [7:0] IDX_FORCE_VAL = 8'h13;
    localparam logic [7:0] IDX_RAW = 8'h14;
    localparam logic [7:0] IDX_THRESHOLD = 8'h15;
    localparam logic [7:0] IDX_ROUTE_EN = 8'h17;
    localparam logic [7:0] IDX_ROUTE_BASE = 8'h40;
    localparam logic [31:0] RST_WORD = 32'h0000_0000;

    // ------------------------------------------------------------
    // routing source codes
    // ------------------------------------------------------------
    localparam logic [6:0] SRC_ZERO = 7'h00;
    localparam logic [6:0] SRC_PHYS_LO = 7'h01;
    localparam logic [6:0] SRC_PHYS_HI = 7'h10;
    localparam logic [6:0] SRC_HALL_U = 7'h41;
    localparam logic [6:0] SRC_HALL_V = 7'h42;
    localparam logic [6:0] SRC_HALL_W = 7'h43;
    localparam logic [6:0] SRC_ENC_A = 7'h44;
    localparam logic [6:0] SRC_ENC_B = 7'h45;
    localparam logic [6:0] SRC_ENC_IDX = 7'h46;
    localparam logic [6:0] SRC_ETH_ACT = 7'h48;
    localparam int SRC_INV_BIT = 7;

    typedef enum logic [1:0] {
        MODE_DIRECT = 2'b01,
        MODE_ROUTE = 2'b10
    } dior_mode_t;

    typedef struct packed {
        logic [NUM_IN-1:0] phys;
        logic [2:0] hall;
        logic [2:0] enc;
        logic eth_active;
    } dior_pins_t;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] idx;
        logic [WORD_W-1:0] wdata;
    } dior_obj_req_t;
endpackage : dior_pkg

// File: dior_top.sv
// Purpose: samples, conditions and routes digital inputs into the
//   input word; drives outputs and brake from the output word
// Assumes: pins synchronous to sys_clk; one object access per cycle
// Notes: input word refreshed every enabled clock from sampled pins
//
// How it works
// - special bits low half, levels high half
// - level of I/O n at bit 15+n
// - bit 16 shows input 1 in direct mode and with preloaded routing
// - inputs sampled once per millisecond tick
// - enable gates special bit, not level
// - bits 0-3: limits, home, interlock
// - polarity bit n-1 inverts input n
// - force enable substitutes force value
// - raw register holds unprocessed samples
// - threshold select bits driven to inputs
// - bit 16 processed, bit 0 negative limit
// - writing 1 enters routing mode
// - entering routing preloads equivalent entries
// - entry k+1 feeds input-word bit k
// - source code decode table
// - code bit 7 inverts source
// - interlock low stops motion, raises fault
// - output n follows output-word bit 15+n
// - output-word bit 0 drives brake
`timescale 1ns/100ps
`default_nettype none
module dior_top #(
    parameter int TICK_CYCLES = dior_pkg::SAMPLE_CYCLES
) (
    input wire logic sys_clk,
    input wire logic arst_n,
    input wire logic clk_en,
    input wire dior_pkg::dior_pins_t pins,
    input wire dior_pkg::dior_obj_req_t obj_req,
    output logic [dior_pkg::WORD_W-1:0] obj_rdata,
    output logic obj_rvalid,
    output logic [dior_pkg::WORD_W-1:0] input_word,
    output logic [dior_pkg::NUM_IN-1:0] threshold_sel,
    output logic [dior_pkg::NUM_IN-1:0] out_pins,
    output logic brake_out,
    output logic motion_enable,
    output logic interlock_fault
);
    import dior_pkg::*;

    localparam int CNT_W = $clog2(TICK_CYCLES + 1);
    localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(TICK_CYCLES - 1);

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    logic [CNT_W-1:0] tick_cnt_ff;
    dior_pins_t samp_ff;
    logic [WORD_W-1:0] sfe_ff;
    logic [WORD_W-1:0] pol_ff;
    logic [WORD_W-1:0] force_en_ff;
    logic [WORD_W-1:0] force_val_ff;
    logic [WORD_W-1:0] thr_ff;
    logic [WORD_W-1:0] dow_ff;
    logic [WORD_W-1:0] word_ff;
    logic [WORD_W-1:0] rdata_ff;
    logic rvalid_ff;
    logic [NUM_IN-1:0] out_ff;
    logic brake_ff;
    logic motion_ff;
    logic fault_ff;
    dior_mode_t mode_ff;
    logic [7:0] route_ff [NUM_ROUTE];

    // ------------------------------------------------------------
    // decode
    // ------------------------------------------------------------
    wire tick = (tick_cnt_ff == CNT_LAST);
    wire wr = clk_en && obj_req.wr;
    wire wr_sfe = wr && (obj_req.idx == IDX_SF_ENABLE);
    wire wr_pol = wr && (obj_req.idx == IDX_POLARITY);
    wire wr_fen = wr && (obj_req.idx == IDX_FORCE_EN);
    wire wr_fval = wr && (obj_req.idx == IDX_FORCE_VAL);
    wire wr_thr = wr && (obj_req.idx == IDX_THRESHOLD);
    wire wr_dow = wr && (obj_req.idx == IDX_OUTPUT_WORD);
    wire wr_ren = wr && (obj_req.idx == IDX_ROUTE_EN);
    wire in_table = (obj_req.idx >= IDX_ROUTE_BASE) &&
                    (obj_req.idx < IDX_ROUTE_BASE + 8'(NUM_ROUTE));
    wire [4:0] tbl_sel = 5'(obj_req.idx - IDX_ROUTE_BASE);
    wire enter_route = wr_ren && obj_req.wdata[0] &&
                       (mode_ff == MODE_DIRECT);

    // processing order: raw, force, polarity
    wire [NUM_IN-1:0] raw = samp_ff.phys;
    wire [NUM_IN-1:0] forced = (force_en_ff[NUM_IN-1:0] &
                                force_val_ff[NUM_IN-1:0]) |
                               (~force_en_ff[NUM_IN-1:0] & raw);
    wire [NUM_IN-1:0] lvl = forced ^ pol_ff[NUM_IN-1:0];

    // ------------------------------------------------------------
    // routing source select
    // ------------------------------------------------------------
    function automatic logic route_pick(input logic [7:0] code,
                                        input logic [NUM_IN-1:0] lv,
                                        input dior_pins_t p);
        logic [6:0] c;
        logic v;
        c = code[6:0];
        v = 1'b0;
        if (c >= SRC_PHYS_LO && c <= SRC_PHYS_HI) begin
            v = lv[4'(c - SRC_PHYS_LO)];
        end else begin
            case (c)
                SRC_HALL_U: v = p.hall[0];
                SRC_HALL_V: v = p.hall[1];
                SRC_HALL_W: v = p.hall[2];
                SRC_ENC_A: v = p.enc[0];
                SRC_ENC_B: v = p.enc[1];
                SRC_ENC_IDX: v = p.enc[2];
                SRC_ETH_ACT: v = p.eth_active;
                default: v = 1'b0; // constant 0 and unknown codes
            endcase
        end
        return v ^ code[SRC_INV_BIT];
    endfunction : route_pick

    // ------------------------------------------------------------
    // input word assembly, two bits per g_bits entry, one per g_route entry
    // ------------------------------------------------------------
    logic [WORD_W-1:0] direct_word;
    logic [WORD_W-1:0] routed_word;
    logic [WORD_W-1:0] nxt_word;
    genvar gi;
    generate
        for (gi = 0; gi < NUM_IN; gi++) begin : g_bits
            // special function of input gi+1 sits at bit gi
            assign direct_word[gi] = lvl[gi];
            assign direct_word[LEVEL_LSB+gi] = lvl[gi];
            // enable only touches the special half
            assign nxt_word[gi] = sfe_ff[gi] &
                ((mode_ff == MODE_ROUTE) ? routed_word[gi]
                                         : direct_word[gi]);
            assign nxt_word[LEVEL_LSB+gi] = (mode_ff == MODE_ROUTE) ?
                routed_word[LEVEL_LSB+gi] : direct_word[LEVEL_LSB+gi];
        end
        for (gi = 0; gi < NUM_ROUTE; gi++) begin : g_route
            assign routed_word[gi] = route_pick(route_ff[gi], lvl,
                                                samp_ff);
        end
    endgenerate

    // ------------------------------------------------------------
    // read mux
    // ------------------------------------------------------------
    logic [WORD_W-1:0] rd_mux;
    always_comb begin
        rd_mux = RST_WORD;
        if (in_table) begin
            rd_mux = {24'h00_0000, route_ff[tbl_sel]};
        end else begin
            case (obj_req.idx)
                IDX_INPUT_WORD: rd_mux = word_ff;
                IDX_OUTPUT_WORD: rd_mux = dow_ff;
                IDX_SF_ENABLE: rd_mux = sfe_ff;
                IDX_POLARITY: rd_mux = pol_ff;
                IDX_FORCE_EN: rd_mux = force_en_ff;
                IDX_FORCE_VAL: rd_mux = force_val_ff;
                IDX_RAW: rd_mux = {16'h0000, raw};
                IDX_THRESHOLD: rd_mux = thr_ff;
                IDX_ROUTE_EN: rd_mux = {31'h0000_0000,
                                        mode_ff == MODE_ROUTE};
                default: rd_mux = RST_WORD;
            endcase
        end
    end

    // ------------------------------------------------------------
    // sampling tick
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            tick_cnt_ff <= '0;
            samp_ff <= '0;
        end else if (clk_en) begin
            tick_cnt_ff <= tick ? '0 : tick_cnt_ff + CNT_W'(1);
            if (tick) begin
                samp_ff <= pins;
            end
        end
    end

    // ------------------------------------------------------------
    // configuration objects
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            sfe_ff <= RST_WORD;
            pol_ff <= RST_WORD;
            force_en_ff <= RST_WORD;
            force_val_ff <= RST_WORD;
            thr_ff <= RST_WORD;
            dow_ff <= RST_WORD;
        end else begin
            if (wr_sfe) sfe_ff <= obj_req.wdata;
            if (wr_pol) pol_ff <= obj_req.wdata;
            if (wr_fen) force_en_ff <= obj_req.wdata;
            if (wr_fval) force_val_ff <= obj_req.wdata;
            if (wr_thr) thr_ff <= obj_req.wdata;
            if (wr_dow) dow_ff <= obj_req.wdata;
        end
    end

    // ------------------------------------------------------------
    // routing mode and table
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            mode_ff <= MODE_DIRECT;
        end else if (wr_ren) begin
            mode_ff <= obj_req.wdata[0] ? MODE_ROUTE : MODE_DIRECT;
        end
    end

    // preload keeps every bit on its direct source, so the switch
    // is seamless; toggling back and forth loses custom entries
    generate
        for (gi = 0; gi < NUM_ROUTE; gi++) begin : g_tbl
            localparam logic [7:0] DFLT = 8'((gi % NUM_IN) + 1);
            always_ff @(posedge sys_clk or negedge arst_n) begin
                if (!arst_n) begin
                    route_ff[gi] <= 8'h00;
                end else if (enter_route) begin
                    route_ff[gi] <= DFLT;
                end else if (wr && in_table && tbl_sel == 5'(gi)) begin
                    route_ff[gi] <= obj_req.wdata[7:0];
                end
            end
        end
    endgenerate

    // ------------------------------------------------------------
    // word, outputs, interlock, read answer
    // ------------------------------------------------------------
    wire il_block = sfe_ff[SF_INTERLOCK] && !word_ff[SF_INTERLOCK];

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            word_ff <= RST_WORD;
            out_ff <= '0;
            brake_ff <= 1'b0;
            motion_ff <= 1'b1;
            fault_ff <= 1'b0;
            rdata_ff <= RST_WORD;
            rvalid_ff <= 1'b0;
        end else if (clk_en) begin
            word_ff <= nxt_word;
            out_ff <= dow_ff[LEVEL_LSB +: NUM_IN];
            brake_ff <= dow_ff[OUT_BRAKE];
            motion_ff <= !il_block;
            fault_ff <= il_block;
            rvalid_ff <= obj_req.rd;
            if (obj_req.rd) rdata_ff <= rd_mux;
        end
    end

    assign obj_rdata = rdata_ff;
    assign obj_rvalid = rvalid_ff;
    assign input_word = word_ff;
    assign threshold_sel = thr_ff[NUM_IN-1:0];
    assign out_pins = out_ff;
    assign brake_out = brake_ff;
    assign motion_enable = motion_ff;
    assign interlock_fault = fault_ff;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    property p_level_direct;
        @(posedge sys_clk) disable iff (!arst_n)
        clk_en && mode_ff == MODE_DIRECT && !force_en_ff[0] && !pol_ff[0]
        |=> word_ff[LEVEL_LSB] == $past(samp_ff.phys[0]);
    endproperty
    a_level_direct: assert property (p_level_direct)
        else $error("level bit 16 differs from sampled input 1");

    property p_sf_gate;
        @(posedge sys_clk) disable iff (!arst_n)
        clk_en && !sfe_ff[SF_NEG_LIMIT] |=> !word_ff[SF_NEG_LIMIT];
    endproperty
    a_sf_gate: assert property (p_sf_gate)
        else $error("special bit set while its enable is off");

    property p_force;
        @(posedge sys_clk) disable iff (!arst_n)
        clk_en && mode_ff == MODE_DIRECT && force_en_ff[1] && !pol_ff[1]
        |=> word_ff[LEVEL_LSB+1] == $past(force_val_ff[1]);
    endproperty
    a_force: assert property (p_force)
        else $error("forced value not seen on input 2");

    property p_polarity;
        @(posedge sys_clk) disable iff (!arst_n)
        clk_en && mode_ff == MODE_DIRECT && !force_en_ff[2] && pol_ff[2]
        |=> word_ff[LEVEL_LSB+2] != $past(samp_ff.phys[2]);
    endproperty
    a_polarity: assert property (p_polarity)
        else $error("normally closed input 3 not inverted");

    property p_sample;
        @(posedge sys_clk) disable iff (!arst_n)
        !(clk_en && tick) |=> $stable(samp_ff);
    endproperty
    a_sample: assert property (p_sample)
        else $error("inputs sampled away from the tick");

    property p_route_const;
        @(posedge sys_clk) disable iff (!arst_n)
        clk_en && mode_ff == MODE_ROUTE && route_ff[LEVEL_LSB] == 8'h80
        |=> word_ff[LEVEL_LSB];
    endproperty
    a_route_const: assert property (p_route_const)
        else $error("inverted constant zero source did not give one");

    property p_route_load;
        @(posedge sys_clk) disable iff (!arst_n)
        enter_route |=> route_ff[0] == 8'h01 &&
                        route_ff[LEVEL_LSB+3] == 8'h04 &&
                        mode_ff == MODE_ROUTE;
    endproperty
    a_route_load: assert property (p_route_load)
        else $error("routing entries not preloaded on entry");

    property p_interlock;
        @(posedge sys_clk) disable iff (!arst_n)
        clk_en && sfe_ff[SF_INTERLOCK] && !word_ff[SF_INTERLOCK]
        |=> !motion_enable && interlock_fault;
    endproperty
    a_interlock: assert property (p_interlock)
        else $error("motion allowed with interlock low");

    property p_outputs;
        @(posedge sys_clk) disable iff (!arst_n)
        wr_dow ##1 clk_en && !wr_dow
        |=> out_pins == $past(obj_req.wdata[31:16], 2) &&
            brake_out == $past(obj_req.wdata[0], 2);
    endproperty
    a_outputs: assert property (p_outputs)
        else $error("outputs do not follow the output word");

    // enable low must hold every register, tick counter included,
    // or a paused controller would drift off its sample grid
    property p_freeze;
        @(posedge sys_clk) disable iff (!arst_n)
        !clk_en |=> $stable(word_ff) && $stable(tick_cnt_ff) &&
                    $stable(dow_ff) && $stable(samp_ff);
    endproperty
    a_freeze: assert property (p_freeze)
        else $error("state moved while the clock enable was low");

    property p_raw_read;
        @(posedge sys_clk) disable iff (!arst_n)
        clk_en && obj_req.rd && obj_req.idx == IDX_RAW
        |=> obj_rvalid && obj_rdata == {16'h0000, $past(samp_ff.phys)};
    endproperty
    a_raw_read: assert property (p_raw_read)
        else $error("raw read differs from the unprocessed sample");

    property p_route_bit0;
        @(posedge sys_clk) disable iff (!arst_n)
        clk_en && mode_ff == MODE_ROUTE && route_ff[0] == 8'h01 &&
        sfe_ff[SF_NEG_LIMIT]
        |=> word_ff[SF_NEG_LIMIT] == $past(lvl[0]);
    endproperty
    a_route_bit0: assert property (p_route_bit0)
        else $error("entry one did not feed input-word bit 0");

    property p_brake;
        @(posedge sys_clk) disable iff (!arst_n)
        clk_en |=> brake_out == $past(dow_ff[OUT_BRAKE]);
    endproperty
    a_brake: assert property (p_brake)
        else $error("brake output does not follow output-word bit 0");
endmodule : dior_top
`default_nettype wire

// File: dior_pins_model.sv
// Purpose: far-side switches, Hall, encoder and link-status lines
// Assumes: levels commanded by the bench, held between commands
// Notes: levels move one edge after a command, like a real contact
`timescale 1ns/100ps
`default_nettype none
module dior_pins_model (
    input wire logic sys_clk,
    input wire logic [15:0] set_phys,
    input wire logic [2:0] set_hall,
    input wire logic [2:0] set_enc,
    input wire logic set_eth,
    output var dior_pkg::dior_pins_t pins
);
    import dior_pkg::*;
    // no bounce modelled; every level is always driven
    always_ff @(posedge sys_clk) begin
        pins <= '{phys: set_phys, hall: set_hall, enc: set_enc,
                  eth_active: set_eth};
    end
endmodule : dior_pins_model
`default_nettype wire

// File: dior_top_bench.sv
// Purpose: self-checking bench for input conditioning and outputs
// Assumes: short sample tick of 8 cycles
// Notes: expectations worked out here, except the word kept across the routing switch
`timescale 1ns/100ps
`default_nettype none
module dior_top_bench;
    import dior_pkg::*;
    localparam int TICK = 8;
    logic sys_clk = 1'b0;
    logic arst_n = 1'b0;
    logic clk_en = 1'b1;
    dior_obj_req_t req = '0;
    logic [15:0] phys = 16'h0000;
    logic [2:0] hall = 3'h0;
    logic [2:0] enc = 3'h0;
    logic eth = 1'b0;
    dior_pins_t pins;
    logic [31:0] rdata;
    logic [31:0] iw;
    logic [15:0] thr;
    logic [15:0] outp;
    logic rvalid, brk, mot, flt;
    int errors = 0;
    int num_checks = 0;
    int cyc = 0;
    logic [31:0] dw;
    logic [7:0] codes [10] = '{8'h00, 8'h01, 8'h10, 8'h41, 8'h42,
                               8'h43, 8'h44, 8'h45, 8'h46, 8'h48};
    logic ev [10] = '{1'b0, 1'b1, 1'b1, 1'b0, 1'b1, 1'b0, 1'b0,
                      1'b1, 1'b0, 1'b1};

    always #25 sys_clk = ~sys_clk;

    dior_pins_model u_far (.sys_clk(sys_clk), .set_phys(phys),
        .set_hall(hall), .set_enc(enc), .set_eth(eth), .pins(pins));

    dior_top #(.TICK_CYCLES(TICK)) u_dut (.sys_clk(sys_clk),
        .arst_n(arst_n), .clk_en(clk_en), .pins(pins), .obj_req(req),
        .obj_rdata(rdata), .obj_rvalid(rvalid), .input_word(iw),
        .threshold_sel(thr), .out_pins(outp), .brake_out(brk),
        .motion_enable(mot), .interlock_fault(flt));

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    task automatic finish_test;
        if (errors == 0 && num_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : finish_test

    // hang guard, well above the few hundred cycles the run needs
    always @(posedge sys_clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            errors++;
            finish_test();
        end
    end

    task automatic chk(input string nm, input logic [31:0] e,
                       input logic [31:0] g);
        num_checks++;
        if (g !== e) begin
            errors++;
            $display("[ERR] %s exp %h got %h", nm, e, g);
        end
    endtask : chk

    task automatic step(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask : step

    // strobe dropped a full cycle before the next request
    task automatic wr(input logic [7:0] i, input logic [31:0] d);
        req = '{wr: 1'b1, rd: 1'b0, idx: i, wdata: d};
        step(1);
        req.wr = 1'b0;
        step(1);
    endtask : wr

    task automatic rd(input logic [7:0] i, input logic [31:0] e,
                      input string nm);
        req = '{wr: 1'b0, rd: 1'b1, idx: i, wdata: 32'h0};
        step(1);
        req.rd = 1'b0;
        chk("rvalid", 32'h1, {31'h0, rvalid});
        chk(nm, e, rdata);
        step(1);
    endtask : rd

    function automatic logic [31:0] dexp(input logic [15:0] r, fe, fv,
                                         pol, sf);
        logic [15:0] l;
        l = ((fe & fv) | (~fe & r)) ^ pol;
        return {l, l & sf};
    endfunction : dexp

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_reset;
        rd(IDX_SF_ENABLE, 32'h0, "sf_enable");
        rd(IDX_POLARITY, 32'h0, "polarity");
        rd(IDX_FORCE_EN, 32'h0, "force_en");
        rd(IDX_ROUTE_EN, 32'h0, "route_en");
        chk("motion", 32'h1, {31'h0, mot});
        chk("fault", 32'h0, {31'h0, flt});
        chk("out", 32'h0, {16'h0, outp});
        chk("brake", 32'h0, {31'h0, brk});
        rd(8'h33, 32'h0, "unmapped");
    endtask : t_reset

    task automatic t_direct;
        phys = 16'ha5c3;
        step(2 * TICK + 4);
        chk("iw plain", dexp(16'ha5c3, '0, '0, '0, '0), iw);
        wr(IDX_SF_ENABLE, 32'h0000_000f);
        wr(IDX_POLARITY, 32'h0000_0105);
        wr(IDX_FORCE_EN, 32'h0000_8003);
        wr(IDX_FORCE_VAL, 32'h0000_0002);
        step(1);
        dw = dexp(16'ha5c3, 16'h8003, 16'h0002, 16'h0105, 16'h000f);
        chk("iw cond", dw, iw);
        chk("fault", 32'h1, {31'h0, flt});
        chk("motion", 32'h0, {31'h0, mot});
        wr(IDX_RAW, 32'hffff_ffff);
        rd(IDX_RAW, 32'h0000_a5c3, "raw");
        rd(IDX_INPUT_WORD, dw, "iw read");
    endtask : t_direct

    task automatic t_outputs;
        wr(IDX_THRESHOLD, 32'h0000_5a3c);
        chk("thresh", 32'h5a3c, {16'h0, thr});
        wr(IDX_OUTPUT_WORD, 32'h0002_0001);
        step(1);
        chk("out", 32'h0002, {16'h0, outp});
        chk("brake", 32'h1, {31'h0, brk});
        wr(IDX_OUTPUT_WORD, 32'h8001_0000);
        step(1);
        chk("out", 32'h8001, {16'h0, outp});
        chk("brake", 32'h0, {31'h0, brk});
        rd(IDX_OUTPUT_WORD, 32'h8001_0000, "out word");
    endtask : t_outputs

    task automatic t_route;
        dw = iw;
        wr(IDX_ROUTE_EN, 32'h1);
        step(1);
        chk("iw kept", dw, iw);
        rd(IDX_ROUTE_BASE, 32'h1, "entry1");
        rd(IDX_ROUTE_BASE + 8'd16, 32'h1, "entry17");
        wr(IDX_FORCE_EN, 32'h0);
        wr(IDX_POLARITY, 32'h0);
        hall = 3'b010;
        enc = 3'b010;
        eth = 1'b1;
        step(2 * TICK + 4);
        for (int v = 0; v < 2; v++) begin
            for (int i = 0; i < 10; i++) begin
                wr(IDX_ROUTE_BASE + 8'd16, {24'h0, codes[i] | 8'(v << 7)});
                chk("route", {31'h0, ev[i] ^ v[0]},
                    {31'h0, iw[16]});
            end
        end
        wr(IDX_ROUTE_BASE + 8'd16, 32'h01);
    endtask : t_route

    task automatic t_interlock;
        phys = 16'ha5cb;
        wr(IDX_ROUTE_BASE + 8'd3, 32'h04);
        step(2 * TICK + 4);
        chk("motion", 32'h1, {31'h0, mot});
        chk("fault", 32'h0, {31'h0, flt});
        wr(IDX_ROUTE_BASE + 8'd3, 32'h84);
        step(1);
        chk("motion", 32'h0, {31'h0, mot});
        chk("fault", 32'h1, {31'h0, flt});
        wr(IDX_ROUTE_BASE + 8'd3, 32'h80);
        step(1);
        chk("motion", 32'h1, {31'h0, mot});
    endtask : t_interlock

    // a short dip placed between two ticks must not reach the word
    task automatic t_sample;
        phys = 16'h25cb;
        for (int i = 0; i < 40 && iw[31] !== 1'b0; i++) step(1);
        chk("input 16 low", 32'h0, {31'h0, iw[31]});
        phys = 16'h25ca;
        step(4);
        phys = 16'h25cb;
        for (int i = 0; i < 10; i++) begin
            chk("pulse", 32'h1, {31'h0, iw[16]});
            step(1);
        end
    endtask : t_sample

    // enable low: writes, tick and every register stand still
    task automatic t_freeze;
        clk_en = 1'b0;
        phys = 16'h25ca;
        wr(IDX_OUTPUT_WORD, 32'h0001_0001);
        step(2 * TICK);
        chk("frozen iw", 32'h1, {31'h0, iw[16]});
        chk("frozen out", 32'h8001, {16'h0, outp});
        clk_en = 1'b1;
        step(2 * TICK + 4);
        chk("thawed iw", 32'h0, {31'h0, iw[16]});
        chk("lost write", 32'h0, {31'h0, brk});
    endtask : t_freeze

    // second reset in mid-run, with routing and enables still set
    task automatic t_rereset;
        arst_n = 1'b0;
        step(2);
        arst_n = 1'b1;
        step(1);
        t_reset();
        rd(IDX_ROUTE_BASE + 8'd3, 32'h0, "entry4");
        step(2 * TICK + 4);
        chk("iw direct", dexp(16'h25ca, '0, '0, '0, '0), iw);
    endtask : t_rereset

    initial begin
        repeat (20) @(posedge sys_clk);
        #1;
        arst_n = 1'b1;
        step(1);
        t_reset();
        t_direct();
        t_outputs();
        t_route();
        t_interlock();
        t_sample();
        t_freeze();
        t_rereset();
        finish_test();
    end
endmodule : dior_top_bench
`default_nettype wire
